/* File: common/bcast_pkg.sv */
package bcast_pkg;
  // ****************************************
  // identifiers
  // ****************************************
  localparam logic [10:0] BROADCAST_ID = 11'h280;
  localparam logic [10:0] REQUEST_BASE = 11'h140;
  localparam logic [10:0] REPLY_BASE = 11'h240;
  localparam logic [10:0] CONFIG_ID = 11'h300;
  // ****************************************
  // command codes and fields
  // ****************************************
  localparam logic [7:0] CMD_SHUTDOWN = 8'h80;
  localparam logic [7:0] CMD_POS_READ = 8'h60;
  localparam logic [7:0] CMD_NODE_ID = 8'h79;
  localparam logic [7:0] SEL_READ = 8'h01;
  localparam logic [7:0] SEL_WRITE = 8'h00;
  localparam logic [5:0] NODE_MIN = 6'h01;
  localparam logic [5:0] NODE_MAX = 6'h20;
  localparam logic [5:0] NODE_RESET = 6'h01;
  localparam logic [2:0] SYNC_STAGES = 3'h3;
  // ****************************************
  // types
  // ****************************************
  typedef logic [7:0] byte_t;
  typedef byte_t [7:0] payload_t;
endpackage

/* File: common/frame_if.sv */
`timescale 1ns/1ps
interface frame_if;
  import bcast_pkg::*;
  logic valid;
  logic [10:0] id;
  payload_t data;
  modport src (output valid, output id, output data);
  modport dst (input valid, input id, input data);
endinterface

/* File: hw/bcast_cmd.sv */
`timescale 1ns/1ps
module bcast_cmd
  import bcast_pkg::*;
#(
  // highest node number served; the node field is six bits and node zero is no address
  parameter int NODE_LIMIT = 32
)
(
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  input wire logic rx_valid_in,
  input wire logic [10:0] rx_id_in,
  input wire payload_t rx_data_in,
  input wire logic id_filter_en_in,
  input wire logic [31:0] position_in,
  input wire logic tx_ready_in,
  output logic tx_valid_out,
  output logic [10:0] tx_id_out,
  output payload_t tx_data_out,
  output logic shutdown_out,
  output logic [5:0] node_identifier_out,
  output logic cmd_valid_out,
  output logic [7:0] cmd_code_out,
  output payload_t cmd_data_out,
  output logic bad_request_out
);
  // ****************************************
  // receive path
  // ****************************************
  // the front end turns the pin strobe into a one-cycle frame pulse
  frame_if rx ();
  frame_sync u_sync (
    .ref_clk_in(ref_clk_in),
    .arst_n_in(arst_n_in),
    .rx_valid_in(rx_valid_in),
    .rx_id_in(rx_id_in),
    .rx_data_in(rx_data_in),
    .frm(rx)
  );

  // ****************************************
  // elaboration checks
  // ****************************************
  // a node limit beyond six bits would wrap when cut to the six-bit NODE_TOP below,
  // and node zero would collide with the base identifiers themselves
  if (NODE_LIMIT < 1 || NODE_LIMIT > 63)
  begin
    $error("bcast_cmd: NODE_LIMIT must lie between 1 and 63");
  end
  localparam logic [5:0] NODE_TOP = 6'(NODE_LIMIT);

  // ****************************************
  // state
  // ****************************************
  // filter enable is a pin level, so it passes three flops; a change
  // counts only once the second and third agree
  typedef struct packed {
    logic [2:0] flt;
    logic flt_on;
    logic tx_valid;
    logic [10:0] tx_id;
    payload_t tx_data;
    logic shutdown;
    logic [5:0] node;
    logic cmd_valid;
    logic [7:0] cmd_code;
    payload_t cmd_data;
    logic bad;
  } state_s;
  state_s q, d;

  // frame classification and reply fields, all from registered state
  logic filter_on;
  logic is_bcast;
  logic is_own;
  logic is_cfg;
  logic [10:0] own_reply;
  logic [7:0] code;
  logic fields_ok;
  logic [5:0] new_node;
  logic [10:0] read_id;
  // ****************************************
  // identifier match
  // ****************************************
  // the filter level is the agreed one, so a single odd sample cannot drop a broadcast
  assign filter_on = q.flt_on;
  assign own_reply = REPLY_BASE + {5'h00, q.node};
  // the command byte always sits in the first payload byte
  assign code = rx.data[0];
  assign is_bcast = rx.valid && rx.id == BROADCAST_ID && !filter_on;
  // own request identifier follows the node number from the frame after a write
  assign is_own = rx.valid && rx.id == REQUEST_BASE + {5'h00, q.node};
  assign is_cfg = rx.valid && rx.id == CONFIG_ID && code == CMD_NODE_ID;
  // a node command with stray bytes in 1 or 3 to 6, or a selector other than 0 or 1, is refused
  assign fields_ok = rx.data[1] == SEL_WRITE && rx.data[3] == SEL_WRITE && rx.data[4] == SEL_WRITE
    && rx.data[5] == SEL_WRITE && rx.data[6] == SEL_WRITE
    && (rx.data[2] == SEL_READ || rx.data[2] == SEL_WRITE);
  // only the low six bits name a node; the top two are checked for zero
  assign new_node = rx.data[7][5:0];
  // a read reports the reply identifier, which follows the node number
  assign read_id = own_reply;

  // ****************************************
  // command decode and reply build
  // ****************************************
  // one frame is decoded per strobe; frames need two idle cycles between
  // them, which the front end's edge detector relies on; there is no queue,
  // so the cost of a busy bus is a lost older reply
  // a stalled reply is overwritten by a newer one; the host sees the latest answer
  always_comb
  begin
    d = q;
    d.flt = {q.flt[1:0], id_filter_en_in};
    if (q.flt[2] == q.flt[1])
      d.flt_on = q.flt[2];
    // strobes last one cycle; the reply stays until the host takes it
    d.cmd_valid = 1'b0;
    d.bad = 1'b0;
    // the host took the pending reply; a new reply in the same cycle wins below
    if (q.tx_valid && tx_ready_in)
      d.tx_valid = 1'b0;
    if (is_cfg)
    begin
      // node-number command answers on the configuration identifier
      if (!fields_ok)
        d.bad = 1'b1;
      else if (rx.data[2] == SEL_READ)
      begin
        d.tx_valid = 1'b1;
        d.tx_id = CONFIG_ID;
        d.tx_data = '0;
        // the read answer carries the reply identifier, low byte first
        d.tx_data[0] = CMD_NODE_ID;
        d.tx_data[2] = SEL_READ;
        d.tx_data[6] = read_id[7:0];
        d.tx_data[7] = {5'h00, read_id[10:8]};
      end
      else if (rx.data[7][7:6] == 2'h0 && new_node >= NODE_MIN && new_node <= NODE_TOP)
      begin
        // new identifiers apply from the next frame on
        d.node = new_node;
        d.tx_valid = 1'b1;
        d.tx_id = CONFIG_ID;
        d.tx_data = rx.data;
      end
      else
        d.bad = 1'b1;
    end
    else if (is_bcast || is_own)
    begin
      // the command goes to the rest of the drive whatever its code
      d.cmd_valid = 1'b1;
      d.cmd_code = code;
      d.cmd_data = rx.data;
      // only stop and position read build a reply here
      if (code == CMD_SHUTDOWN)
      begin
        d.shutdown = 1'b1;
        d.tx_valid = 1'b1;
        d.tx_id = own_reply;
        d.tx_data = '0;
        d.tx_data[0] = CMD_SHUTDOWN;
      end
      else if (code == CMD_POS_READ)
      begin
        d.tx_valid = 1'b1;
        d.tx_id = own_reply;
        d.tx_data = '0;
        d.tx_data[0] = CMD_POS_READ;
        // position bytes go out least significant first
        d.tx_data[4] = position_in[7:0];
        d.tx_data[5] = position_in[15:8];
        d.tx_data[6] = position_in[23:16];
        d.tx_data[7] = position_in[31:24];
      end
      else
        d.shutdown = 1'b0; // any other command releases the stop
    end
  end

  // ****************************************
  // state register
  // ****************************************
  // asynchronous reset puts the drive on node one and its reply identifier,
  // so a drive that lost its setting still answers somewhere known
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      q <= '0;
      q.node <= NODE_RESET;
      q.tx_id <= REPLY_BASE + {5'h00, NODE_RESET};
    end
    else
      q <= d;
  end

  // ****************************************
  // outputs
  // ****************************************
  // every output is a field of the state register, so no decode glitch
  // reaches a pin
  assign tx_valid_out = q.tx_valid;
  assign tx_id_out = q.tx_id;
  assign tx_data_out = q.tx_data;
  assign shutdown_out = q.shutdown;
  assign node_identifier_out = q.node;
  assign cmd_valid_out = q.cmd_valid;
  assign cmd_code_out = q.cmd_code;
  assign cmd_data_out = q.cmd_data;
  assign bad_request_out = q.bad;
endmodule

/* File: hw/frame_sync.sv */
`timescale 1ns/1ps
// ****************************************
// receive frame capture
// ****************************************
module frame_sync
  import bcast_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  input wire logic rx_valid_in,
  input wire logic [10:0] rx_id_in,
  input wire payload_t rx_data_in,
  frame_if.src frm
);
  typedef struct packed {
    logic [2:0] vs;
    logic lvl;
    logic [10:0] id;
    payload_t data;
    logic vld;
  } sync_s;
  sync_s q, d;
  // valid strobe passes three flops; a level change counts only once the
  // second and third agree, so one odd sample cannot make a false frame
  always_comb
  begin
    d = q;
    d.vs = {q.vs[1:0], rx_valid_in};
    if (q.vs[1] == q.vs[2])
      d.lvl = q.vs[2];
    d.vld = q.vs[2] & q.vs[1] & ~q.lvl;
    // id and data are taken a cycle early, while the strobe is surely still high
    if (q.vs[1] & ~q.vs[2])
    begin
      d.id = rx_id_in;
      d.data = rx_data_in;
    end
  end
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      q <= '0;
    else
      q <= d;
  end
  assign frm.valid = q.vld;
  assign frm.id = q.id;
  assign frm.data = q.data;
endmodule

/* File: tb/bcast_cmd_sva.sv */
`timescale 1ns/1ps
module bcast_cmd_sva
  import bcast_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  input wire logic tx_ready_in,
  input wire logic tx_valid_out,
  input wire logic [10:0] tx_id_out,
  input wire payload_t tx_data_out,
  input wire logic shutdown_out,
  input wire logic [5:0] node_identifier_out,
  input wire logic cmd_valid_out,
  input wire logic [7:0] cmd_code_out,
  input wire logic bad_request_out
);
  // config replies use the shared id, so id checks skip them
  wire logic own = tx_valid_out && tx_id_out != CONFIG_ID;
  default clocking @(posedge ref_clk_in);
  endclocking
  default disable iff (!arst_n_in);
  a_node_range: assert property (node_identifier_out inside {[NODE_MIN:NODE_MAX]}) else $error("node range");
  a_reply_id: assert property (own |-> tx_id_out == REPLY_BASE + 11'(node_identifier_out))
    else $error("reply id");
  a_stop_reply: assert property (own && tx_data_out[0] == CMD_SHUTDOWN |-> tx_data_out[7:1] == '0)
    else $error("stop pad");
  a_pos_pad: assert property (own && tx_data_out[0] == CMD_POS_READ |-> tx_data_out[3:1] == '0)
    else $error("position pad");
  a_stop_level: assert property (cmd_valid_out && cmd_code_out == CMD_SHUTDOWN |-> shutdown_out)
    else $error("stop not raised");
  a_cmd_pulse: assert property (cmd_valid_out |=> !cmd_valid_out) else $error("strobe long");
  a_bad_alone: assert property (bad_request_out |-> !cmd_valid_out ##1 !bad_request_out)
    else $error("bad request");
  a_reply_stands: assert property (tx_valid_out && !tx_ready_in |=> tx_valid_out) else $error("reply lost");
  a_node_moves: assert property (!$stable(node_identifier_out) |-> tx_valid_out && !own
    && tx_data_out[7] == 8'(node_identifier_out)) else $error("node moved");
endmodule

/* File: tb/host_model.sv */
`timescale 1ns/1ps
module host_model
(
  input wire logic ref_clk_in,
  input wire logic tx_valid_in,
  input wire logic hold_in,
  output logic tx_ready_out
);
  // takes a reply a cycle late; hold_in plays a busy bus
  always @(posedge ref_clk_in)
    tx_ready_out <= tx_valid_in && !tx_ready_out && !hold_in;
endmodule

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import bcast_pkg::*;
  typedef struct {logic [10:0] id; payload_t d; logic [10:0] eid; payload_t ed;} row_s;
  logic ref_clk_in = 0, arst_n_in = 0, rx_valid_in = 0, id_filter_en_in = 0, hold = 0, got, seen_bad;
  logic tx_ready_in, tx_valid_out, shutdown_out, cmd_valid_out, bad_request_out;
  logic [10:0] rx_id_in = '0, tx_id_out, seen_id;
  logic [5:0] node_identifier_out;
  logic [7:0] cmd_code_out;
  logic [31:0] position_in = 32'h44332710;
  payload_t rx_data_in = '0, tx_data_out, cmd_data_out, seen_d;
  int n_errors = 0, comparisons = 0;
  // stop, position, node write, node read, stop on new own id
  row_s rows [5] = '{'{11'h280, 64'h80, 11'h241, 64'h80}, '{11'h280, 64'h60, 11'h241, 64'h4433271000000060},
    '{11'h300, 64'h0200000000000079, 11'h300, 64'h0200000000000079},
    '{11'h300, 64'h10079, 11'h300, 64'h0242000000010079}, '{11'h142, 64'h80, 11'h242, 64'h80}};
  bcast_cmd uut (.*);
  host_model host (.ref_clk_in, .tx_valid_in(tx_valid_out), .hold_in(hold), .tx_ready_out(tx_ready_in));
  // 10 MHz
  initial forever #50 ref_clk_in = ~ref_clk_in;
  // compare and count
  task automatic chk(input logic [79:0] seen, input logic [79:0] exp);
    comparisons++;
    n_errors += int'(seen !== exp);
    if (seen !== exp)
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
  endtask
  task automatic tally_and_finish;
    $display("errors %0d of %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // one frame held until an answer shows, bounded so a hang cannot stall us
  task automatic xfer(input logic [10:0] id, input payload_t d);
    got = 0;
    @(negedge ref_clk_in);
    {rx_valid_in, rx_id_in, rx_data_in} = {1'b1, id, d};
    for (int k = 0; k < 10 && !got; k++)
    begin
      @(negedge ref_clk_in);
      got = tx_valid_out === 1'b1 || bad_request_out === 1'b1;
      {seen_bad, seen_id, seen_d} = {bad_request_out, tx_id_out, tx_data_out};
    end
    {hold, rx_valid_in} = 2'b00;
    repeat (4) @(negedge ref_clk_in);
  endtask
  // table, then refusals and a second reset
  initial
  begin
    repeat (2) @(negedge ref_clk_in);
    arst_n_in = 1;
    foreach (rows[i])
    begin
      hold = i == 0;
      xfer(rows[i].id, rows[i].d);
      chk({got, seen_id, seen_d}, {1'b1, rows[i].eid, rows[i].ed});
    end
    chk({shutdown_out, node_identifier_out}, {1'b1, 6'h02});
    chk({cmd_code_out, cmd_data_out}, {8'h80, 64'h80});
    id_filter_en_in = 1;
    repeat (4) @(negedge ref_clk_in);
    xfer(11'h280, 64'h60);
    chk(got, 0);
    id_filter_en_in = 0;
    xfer(11'h300, 64'h2100000000000079);
    chk({got, seen_bad, node_identifier_out}, {2'b11, 6'h02});
    xfer(11'h300, 64'h0200000000000179);
    chk({got, seen_bad, node_identifier_out}, {2'b11, 6'h02});
    xfer(11'h300, 64'h20079);
    chk({got, seen_bad, node_identifier_out}, {2'b11, 6'h02});
    arst_n_in = 0;
    @(negedge ref_clk_in);
    chk({node_identifier_out, tx_id_out}, {6'h01, 11'h241});
    arst_n_in = 1;
    xfer(11'h141, 64'h60);
    chk({got, seen_id, seen_d}, {1'b1, 11'h241, 64'h4433271000000060});
    tally_and_finish();
  end
endmodule
bind bcast_cmd bcast_cmd_sva sva (.*);
